// ### core/sed_reset_defaults.sv
// Power-up, soft reset and default state of a serial EEPROM slave
// Notes on behaviour
// - No instruction is taken while power-on reset is active.
// - A select-deselect round trip with no SCK edges in between resets the serial interface.
// - The device becomes active only on a falling chip select edge.
// - Power-up clears the write enable latch.
// - Power-up clears the ready/busy flag, meaning ready.
// - After power-up the device is deselected and not in hold.
// - Lock and block-protect bits survive power-on reset unchanged.
// - The delivered array reads all ones in every byte.
// - The delivered status lock enable bit is zero.
// - Both delivered block-protect bits are zero.
// - The status byte holds lock, protect pair, latch and busy bits.
// - Deselected, serial input is ignored and the output is off.
// - Deselect during hold aborts the operation and clears the latch.
`timescale 1ns/100ps
`default_nettype none
`include "sed_cfg.svh"
module sed_reset_defaults
  import sed_pkg::*;
#(
  parameter int ADDR_W       = 15,
  parameter int WRITE_CYCLES = int'(`SED_WRITE_CYCLES)
) (
  // Clock and power-on reset
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // Serial pins
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              si,
  input  wire logic              hold_n,
  output logic                   so_out,
  output logic                   so_oe_n,
  // Opcode decoder side
  output logic [7:0]             rx_byte,
  output logic                   rx_valid,
  input  wire logic [7:0]        tx_byte,
  input  wire logic              tx_enable,
  input  wire logic              wel_set,
  input  wire logic              wel_clr,
  input  wire logic              wr_req,
  input  wire logic              wr_to_status,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic [7:0]             rd_data,
  // Factory programming
  input  wire logic              factory_init,
  output logic                   factory_busy,
  // State
  output logic [7:0]             status_byte,
  output logic                   dev_ready,
  output logic                   selected,
  output logic                   in_hold,
  output logic                   iface_reset
);

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WRITE_CYCLES - 1);

  // Pin order in the synchroniser: hold_n, si, sck, cs_n
  function automatic logic [3:0] agree_filter(input logic [3:0] s2,
                                              input logic [3:0] s3,
                                              input logic [3:0] held);
    agree_filter = (s2 & s3) | (held & (s2 | s3));
  endfunction

  // Status byte packing, reserved bits zero
  function automatic logic [7:0] pack_status(input sed_prot_type p,
                                             input logic write_enable_latch,
                                             input logic busy);
    pack_status = 8'h00;
    pack_status[`SED_ST_LOCK_BIT]  = p.status_lock_enable;
    pack_status[`SED_ST_BP_HI_BIT] = p.block_protect_hi;
    pack_status[`SED_ST_BP_LO_BIT] = p.block_protect_lo;
    pack_status[`SED_ST_WEL_BIT]   = write_enable_latch;
    pack_status[`SED_ST_BUSY_BIT]  = busy;
  endfunction
  sed_nv_if #(.ADDR_W(ADDR_W)) nv ();
  logic [3:0]        sync1_q, sync2_q, sync3_q, pin_q, pin_prev_q;
  logic              ready_q, armed_q, sck_seen_q, wel_q, iface_rst_q;
  logic              so_q, so_oe_n_q, rx_valid_q, init_q, sel_on_q, hold_q;
  logic [3:0]        bitcnt_q;
  logic [7:0]        rx_sh_q, rx_byte_q, tx_sh_q, status_q;
  sed_sel_type       sel_q, sel_d;
  sed_wr_type        wr_q;
  logic [CNT_W-1:0]  wcnt_q;
  logic              pend_q, pend_st_q;
  logic [ADDR_W-1:0] pend_addr_q;
  logic [7:0]        pend_data_q;

  // Three-stage pin synchroniser; a change counts once stages 2 and 3 agree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q    <= 4'hc; // Select starts low: arming needs a real high
      sync2_q    <= 4'hc;
      sync3_q    <= 4'hc;
      pin_q      <= 4'hc; // False select rise after reset is harmless
      pin_prev_q <= 4'hc;
    end else begin
      sync1_q    <= {hold_n, si, sck, cs_n};
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
      pin_q      <= agree_filter(sync2_q, sync3_q, pin_q);
      pin_prev_q <= pin_q;
    end
  end

  // Filtered pin levels and edges
  wire logic cs_lo    = ~pin_q[0];
  wire logic cs_fall  = pin_prev_q[0] & ~pin_q[0];
  wire logic cs_rise  = ~pin_prev_q[0] & pin_q[0];
  wire logic sck_lo   = ~pin_q[1];
  wire logic sck_rise = ~pin_prev_q[1] & pin_q[1];
  wire logic sck_fall = pin_prev_q[1] & ~pin_q[1];
  wire logic si_lvl   = pin_q[2];
  wire logic hold_lo  = ~pin_q[3];

  // Selection decode
  wire logic active    = (sel_q == SEL_ACTIVE);
  wire logic desel     = (sel_q != SEL_IDLE) && cs_rise;
  wire logic hold_drop = desel && (sel_q == SEL_HOLD);
  wire logic byte_done = active && sck_rise
                         && (bitcnt_q == `SED_BITS_PER_BYTE - 4'h1);
  wire logic write_end = (wr_q == WR_BUSY) && (wcnt_q == '0);
  wire logic take_wr   = active && wr_req && wel_q && (wr_q == WR_IDLE);
  wire logic start_wr  = desel && !hold_drop && pend_q;

  // Selection state; hold entry and exit only while SCK is low
  always_comb begin
    sel_d = sel_q;
    unique case (sel_q)
      SEL_IDLE: begin
        if (ready_q && armed_q && cs_fall) begin
          sel_d = SEL_ACTIVE;
        end
      end
      SEL_ACTIVE: begin
        if (cs_rise) begin
          sel_d = SEL_IDLE;
        end else if (hold_lo && sck_lo) begin
          sel_d = SEL_HOLD;
        end
      end
      SEL_HOLD: begin
        if (cs_rise) begin
          sel_d = SEL_IDLE;
        end else if (!hold_lo && sck_lo) begin
          sel_d = SEL_ACTIVE;
        end
      end
    endcase
  end

  // Power-on reset release and selection; powers up deselected
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_q <= 1'b0;
      armed_q <= 1'b0;
      sel_q   <= SEL_IDLE;
      sel_on_q <= 1'b0;
      hold_q  <= 1'b0;
    end else begin
      ready_q <= 1'b1;
      sel_on_q <= (sel_d != SEL_IDLE);
      hold_q  <= (sel_d == SEL_HOLD);
      // A low chip select at release must first go high
      armed_q <= armed_q | ~cs_lo;
      sel_q   <= sel_d;
    end
  end

  // Serial shifting; edges are ignored unless active and not held
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitcnt_q    <= 4'h0;
      rx_sh_q     <= 8'h00;
      rx_byte_q   <= 8'h00;
      rx_valid_q  <= 1'b0;
      tx_sh_q     <= 8'h00;
      so_q        <= 1'b0;
      sck_seen_q  <= 1'b0;
      iface_rst_q <= 1'b0;
    end else begin
      rx_valid_q  <= byte_done;
      iface_rst_q <= desel && !sck_seen_q;
      if (sel_q == SEL_IDLE || desel) begin
        bitcnt_q   <= 4'h0;
        rx_sh_q    <= 8'h00;
        sck_seen_q <= 1'b0;
      end else begin
        sck_seen_q <= sck_seen_q | sck_rise | sck_fall;
        if (active && sck_rise) begin
          rx_sh_q  <= {rx_sh_q[6:0], si_lvl};
          bitcnt_q <= byte_done ? 4'h0 : bitcnt_q + 4'h1;
        end
        if (byte_done) begin
          rx_byte_q <= {rx_sh_q[6:0], si_lvl};
          tx_sh_q   <= tx_byte;
        end else if (active && sck_fall) begin
          so_q    <= tx_sh_q[7];
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        end
      end
    end
  end

  // Output driven only while active and not paused
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      so_oe_n_q <= 1'b1;
    end else begin
      so_oe_n_q <= ~(sel_d == SEL_ACTIVE && tx_enable);
    end
  end

  // Write enable latch; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wel_q <= 1'b0;
    end else if (active && wel_set) begin
      wel_q <= 1'b1;
    end else if (hold_drop || write_end || (active && wel_clr)) begin
      wel_q <= 1'b0;
    end
  end

  // Pending write, launched when chip select returns high
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q      <= 1'b0;
      pend_st_q   <= 1'b0;
      pend_addr_q <= '0;
      pend_data_q <= 8'h00;
    end else if (take_wr) begin
      pend_q      <= 1'b1;
      pend_st_q   <= wr_to_status;
      pend_addr_q <= wr_addr;
      pend_data_q <= wr_data;
    end else if (hold_drop || write_end) begin
      pend_q      <= 1'b0;
    end
  end

  // Self-timed write engine; busy across the whole count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q   <= WR_IDLE;
      wcnt_q <= '0;
    end else if (start_wr) begin
      wr_q   <= WR_BUSY;
      wcnt_q <= WR_LAST;
    end else if (write_end) begin
      wr_q   <= WR_IDLE;
    end else if (wr_q == WR_BUSY) begin
      wcnt_q <= wcnt_q - 1'b1;
    end
  end

  // Store access; the commit lands in the final busy cycle
  assign nv.arr_we     = write_end && !pend_st_q;
  assign nv.arr_addr   = nv.arr_we ? pend_addr_q : rd_addr;
  assign nv.arr_wdata  = pend_data_q;
  assign nv.prot_we    = write_end && pend_st_q;
  assign nv.prot_wdata = '{pend_data_q[`SED_ST_LOCK_BIT],
                           pend_data_q[`SED_ST_BP_HI_BIT],
                           pend_data_q[`SED_ST_BP_LO_BIT]};
  assign nv.init_req   = init_q;

  // Status byte and factory request registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= 8'h00;
      init_q   <= 1'b0;
    end else begin
      status_q <= pack_status(nv.prot_rdata, wel_q,
                              wr_q == WR_BUSY);
      init_q   <= factory_init && !nv.init_busy && !init_q;
    end
  end

  sed_nv_store #(.ADDR_W(ADDR_W)) u_store (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .nv      (nv)
  );

  // Outputs
  assign so_out       = so_q;
  assign so_oe_n      = so_oe_n_q;
  assign rx_byte      = rx_byte_q;
  assign rx_valid     = rx_valid_q;
  assign rd_data      = nv.arr_rdata;
  assign factory_busy = nv.init_busy;
  assign status_byte  = status_q;
  assign dev_ready    = ready_q;
  assign selected     = sel_on_q;
  assign in_hold      = hold_q;
  assign iface_reset  = iface_rst_q;

endmodule
`default_nettype wire

// ### inc/sed_cfg.svh
// Constants for the serial EEPROM reset and default-state block
`ifndef SED_CFG_SVH
`define SED_CFG_SVH

// Clock rate of ref_clk
`define SED_CLK_HZ           64'd40_000_000
// Self-timed write duration, in microseconds (5 ms)
`define SED_WRITE_TIME_US    64'd5_000
// Cycles of the self-timed write, rounded down as a longest time
`define SED_WRITE_CYCLES     ((`SED_WRITE_TIME_US * `SED_CLK_HZ) / 64'd1_000_000)
// Start-up wait the master keeps after supply is stable, microseconds
`define SED_STARTUP_WAIT_US  64'd100

// Status register field positions
`define SED_ST_LOCK_BIT      7
`define SED_ST_BP_HI_BIT     3
`define SED_ST_BP_LO_BIT     2
`define SED_ST_WEL_BIT       1
`define SED_ST_BUSY_BIT      0

// Delivered values
`define SED_ARRAY_ERASED     8'hff
`define SED_LOCK_DELIVERED   1'b0
`define SED_BP_DELIVERED     2'b00

// Serial byte length
`define SED_BITS_PER_BYTE    4'h8

`endif

// ### inc/sed_pkg.sv
// Types shared by the serial EEPROM reset and default-state block
package sed_pkg;

  // Serial interface selection states
  typedef enum logic [1:0] {
    SEL_IDLE,
    SEL_ACTIVE,
    SEL_HOLD
  } sed_sel_type;

  // Self-timed write engine states
  typedef enum logic {
    WR_IDLE,
    WR_BUSY
  } sed_wr_type;

  // Nonvolatile protection bits
  typedef struct packed {
    logic       status_lock_enable;
    logic       block_protect_hi;
    logic       block_protect_lo;
  } sed_prot_type;

endpackage

// ### inc/sed_nv_if.sv
// Link between the sequencer and its nonvolatile store
`timescale 1ns/100ps
`default_nettype none
interface sed_nv_if #(
  parameter int ADDR_W = 15
);
  import sed_pkg::*;

  logic               arr_we;
  logic [ADDR_W-1:0]  arr_addr;
  logic [7:0]         arr_wdata;
  logic [7:0]         arr_rdata;
  logic               prot_we;
  sed_prot_type       prot_wdata;
  sed_prot_type       prot_rdata;
  logic               init_req;
  logic               init_busy;

  modport ctrl (
    output arr_we, arr_addr, arr_wdata, prot_we, prot_wdata, init_req,
    input  arr_rdata, prot_rdata, init_busy
  );

  modport store (
    input  arr_we, arr_addr, arr_wdata, prot_we, prot_wdata, init_req,
    output arr_rdata, prot_rdata, init_busy
  );
endinterface
`default_nettype wire

// ### core/sed_nv_store.sv
// Nonvolatile array and protection bits, kept across reset
`timescale 1ns/100ps
`default_nettype none
`include "sed_cfg.svh"
module sed_nv_store
  import sed_pkg::*;
#(
  parameter int ADDR_W = 15
) (
  // Clock and reset
  input  wire logic    ref_clk,
  input  wire logic    arst_n,
  // Sequencer side
  sed_nv_if.store      nv
);

  localparam logic [ADDR_W-1:0] LAST_ADDR = {ADDR_W{1'b1}};

  // Cells carry no reset: power-on reset must not touch them
  logic [7:0]        mem [2**ADDR_W];
  sed_prot_type      prot_q;
  logic [7:0]        rdata_q;
  sed_prot_type      prot_rd_q;
  logic              sweep_q;
  logic [ADDR_W-1:0] sweep_addr_q;

  // Address and data chosen between factory sweep and normal use
  wire logic [ADDR_W-1:0] cell_addr = sweep_q ? sweep_addr_q : nv.arr_addr;
  wire logic              cell_we   = sweep_q | nv.arr_we;
  wire logic [7:0]        cell_data = sweep_q ? `SED_ARRAY_ERASED
                                              : nv.arr_wdata;

  // Array cells with registered read data
  always_ff @(posedge ref_clk) begin
    if (cell_we) begin
      mem[cell_addr] <= cell_data;
    end
    rdata_q <= mem[cell_addr];
  end

  // Protection bits; the factory load sets delivered values
  always_ff @(posedge ref_clk) begin
    if (nv.init_req) begin
      prot_q <= sed_prot_type'({`SED_LOCK_DELIVERED,
                                `SED_BP_DELIVERED});
    end else if (nv.prot_we) begin
      prot_q <= nv.prot_wdata;
    end
    prot_rd_q <= prot_q;
  end

  // Factory sweep over the whole array, one byte a cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sweep_q      <= 1'b0;
      sweep_addr_q <= '0;
    end else if (nv.init_req && !sweep_q) begin
      sweep_q      <= 1'b1;
      sweep_addr_q <= '0;
    end else if (sweep_q) begin
      sweep_q      <= (sweep_addr_q != LAST_ADDR);
      sweep_addr_q <= sweep_addr_q + 1'b1;
    end
  end

  assign nv.arr_rdata  = rdata_q;
  assign nv.prot_rdata = prot_rd_q;
  assign nv.init_busy  = sweep_q;

endmodule
`default_nettype wire

// ### dv/sed_reset_defaults_properties.sv
// Checker for power-up, soft reset and busy timing at the top ports
`timescale 1ns/100ps
`default_nettype none
module sed_rd_props #(
  parameter int WRITE_CYCLES = 20
) (
  // Clock and power-on reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // Watched outputs
  input wire logic [7:0] status_byte,
  input wire logic       dev_ready,
  input wire logic       selected,
  input wire logic       in_hold,
  input wire logic       so_oe_n,
  input wire logic       rx_valid,
  input wire logic       iface_reset
);
  int busy_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Length of the running busy spell; a counter avoids a long repetition
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) busy_q <= 0;
    else busy_q <= status_byte[0] ? busy_q + 1 : 0;
  end

  chk_quiet_release: assert property (
    !$past(arst_n) |-> !selected && !rx_valid && !in_hold)
    else $error("activity at reset release");
  chk_ready_after: assert property (
    $past(arst_n) |-> dev_ready)
    else $error("not ready after reset release");
  chk_pup_status: assert property (
    !$past(arst_n) |-> (status_byte[1:0] == 2'b00) [*3])
    else $error("latch or busy set at power-up");
  chk_idle_oe_off: assert property (
    (!selected && !$past(selected)) || (in_hold && $past(in_hold))
    |-> so_oe_n)
    else $error("output driven while idle or paused");
  chk_rx_selected: assert property (
    rx_valid |-> $past(selected))
    else $error("byte taken while deselected");
  chk_busy_length: assert property (
    $fell(status_byte[0]) |-> busy_q == WRITE_CYCLES)
    else $error("busy spell has wrong length");
  chk_wel_at_end: assert property (
    $fell(status_byte[0]) |-> !status_byte[1])
    else $error("latch still set after write");
  chk_soft_reset: assert property (
    iface_reset |-> $past(selected) && !selected ##1 !iface_reset)
    else $error("soft reset pulse misplaced");
endmodule

bind sed_reset_defaults sed_rd_props #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .ref_clk(ref_clk), .arst_n(arst_n), .status_byte(status_byte),
  .dev_ready(dev_ready), .selected(selected), .in_hold(in_hold),
  .so_oe_n(so_oe_n), .rx_valid(rx_valid), .iface_reset(iface_reset));
`default_nettype wire

// ### dv/sed_spi_host.sv
// Behavioural SPI master, mode 0, clock still outside frames
`timescale 1ns/100ps
`default_nettype none
module sed_spi_host #(
  parameter int STARTUP_CYC = 4000
) (
  // Timing reference
  input  wire logic clk,
  // Serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n
);
  // Idle pins: deselected, clock low, not paused
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  // Supply settle wait before the first instruction
  task automatic startup();
    repeat (STARTUP_CYC) @(negedge clk);
  endtask
  task automatic sel();
    @(negedge clk);
    cs_n = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  // SI is inverted, so it stops showing the last bit
  task automatic desel();
    cs_n = 1'b1;
    si = ~si;
    repeat (10) @(negedge clk);
    hold_n = 1'b1;
  endtask
  // Top n bits of b, MSB first, 200 ns per bit
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      si = b[i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
    repeat (4) @(negedge clk);
  endtask
  // Pause entered while the clock is low
  task automatic pause();
    hold_n = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ### dv/tb_sed_reset_defaults.sv
// Self-checking bench for the reset and default-state block
`timescale 1ns/100ps
`default_nettype none
`include "sed_cfg.svh"
module tb_sed_reset_defaults;
  localparam int AW = 4;
  localparam int WC = 20;
  logic          ref_clk, arst_n, cs_n, sck, si, hold_n, so_out, so_oe_n;
  logic          rx_valid, tx_enable, wel_set, wel_clr, wr_req;
  logic          wr_to_status, factory_init, factory_busy, dev_ready;
  logic          selected, in_hold, iface_reset;
  logic [7:0]    rx_byte, tx_byte, wr_data, rd_data, status_byte;
  logic [7:0]    rx_seen, so_seen, d, v;
  logic [AW-1:0] wr_addr, rd_addr, a;
  int            seed, n_fail, checks, n_ir, k;

  sed_spi_host host_u (.clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n));
  sed_reset_defaults #(.ADDR_W(AW), .WRITE_CYCLES(WC)) dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .so_out(so_out), .so_oe_n(so_oe_n),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte(tx_byte),
    .tx_enable(tx_enable), .wel_set(wel_set), .wel_clr(wel_clr),
    .wr_req(wr_req), .wr_to_status(wr_to_status), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .factory_init(factory_init), .factory_busy(factory_busy),
    .status_byte(status_byte), .dev_ready(dev_ready),
    .selected(selected), .in_hold(in_hold), .iface_reset(iface_reset));

  // 40 MHz reference
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // One-cycle pulses are caught between edges
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) rx_seen = rx_byte;
    if (iface_reset === 1'b1) n_ir++;
  end
  // Output bits taken at SCK falls; the design's launch trails the fall
  always @(negedge sck) begin
    so_seen = {so_seen[6:0], so_out};
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Status after power-up or a finished write: latch and busy clear
  function automatic logic [7:0] st_exp(input logic [7:0] p);
    return {p[7], 3'b000, p[3], p[2], 2'b00};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Set the latch, then stage one write
  task automatic stage(input logic ts, input logic [AW-1:0] ad,
                       input logic [7:0] dt);
    wel_set = 1'b1;
    tick(1);
    wel_set = 1'b0;
    tick(3);
    chk({7'h00, status_byte[1]}, 8'h01);
    wr_to_status = ts;
    wr_addr = ad;
    wr_data = dt;
    wr_req = 1'b1;
    tick(1);
    wr_req = 1'b0;
    tick(2);
  endtask
  task automatic wait_idle();
    k = 0;
    while (status_byte[0] !== 1'b0 && k < 100) begin
      tick(1);
      k++;
    end
    tick(2);
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Run takes about 4500 cycles; this bound is far above it
  initial begin
    #1_000_000;
    n_fail++;
    close_out();
  end

  initial begin
    seed = 27;
    n_fail = 0;
    checks = 0;
    n_ir = 0;
    rx_seen = 8'h00;
    so_seen = 8'h00;
    arst_n = 1'b0;
    tx_enable = 1'b1;
    tx_byte = $random(seed);
    wel_set = 1'b0;
    wel_clr = 1'b0;
    wr_req = 1'b0;
    wr_to_status = 1'b0;
    wr_addr = '0;
    wr_data = 8'h00;
    rd_addr = '0;
    factory_init = 1'b0;
    // Chip select already low as reset lifts
    fork
      host_u.sel();
      begin
        tick(2);
        arst_n = 1'b1;
      end
    join
    host_u.startup();
    chk({dev_ready, selected, in_hold, so_oe_n, 4'h0}, 8'h90);
    factory_init = 1'b1;
    tick(1);
    factory_init = 1'b0;
    tick(2);
    chk({7'h00, factory_busy}, 8'h01);
    for (k = 0; k < 40 && factory_busy !== 1'b0; k++) tick(1);
    chk({7'h00, factory_busy}, 8'h00);
    tick(3);
    chk(status_byte, st_exp(8'h00));
    for (int i = 0; i < (1 << AW); i++) begin
      rd_addr = i[AW-1:0];
      tick(1);
      chk(rd_data, `SED_ARRAY_ERASED);
    end
    host_u.desel();
    $display("power-up and delivered state done");
    // Partial byte, then a selection with no clocks
    n_ir = 0;
    d = $random(seed);
    host_u.sel();
    host_u.bits(d, 3);
    host_u.desel();
    host_u.sel();
    host_u.desel();
    chk(n_ir[7:0], 8'h01);
    host_u.sel();
    chk({7'h00, selected}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      host_u.bits(d, 8);
      tick(4);
      chk(rx_seen, d);
      if (i > 0) chk(so_seen, tx_byte);
    end
    host_u.desel();
    $display("soft reset done");
    d = $random(seed);
    host_u.sel();
    stage(1'b1, '0, d);
    host_u.desel();
    chk({7'h00, status_byte[0]}, 8'h01);
    wait_idle();
    chk(status_byte, st_exp(d));
    a = $random(seed);
    v = $random(seed);
    host_u.sel();
    stage(1'b0, a, v);
    host_u.desel();
    wait_idle();
    rd_addr = a;
    tick(1);
    chk(rd_data, v);
    $display("self-timed writes done");
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    tick(4);
    chk(status_byte, st_exp(d));
    chk(rd_data, v);
    $display("second reset done");
    // Deselect while paused drops the staged write
    host_u.sel();
    stage(1'b0, a, ~v);
    host_u.pause();
    chk({7'h00, in_hold}, 8'h01);
    host_u.desel();
    tick(4);
    chk(status_byte, st_exp(d));
    chk(rd_data, v);
    $display("pause abort done");
    close_out();
  end
endmodule
`default_nettype wire
